//--- core/bit_sync.sv
/*
 Two flip-flop synchroniser for a vector of levels.
 Assumes each bit is an independent slow level.
*/
`timescale 1ns/1ps
module bit_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : bit_sync

//--- core/switch_channel_control.sv
/*
 Switch channel control: serial frame receiver on the link clock, register
 bank, thermal and dynamic protection, error flags and gate drive.
 Assumes SPI mode 1 (host drives on rising edge, samples on falling),
 8-bit frames MSB first, and protection inputs from analog comparators.
*/
`timescale 1ns/1ps
`include "switch_channel_control_consts.svh"
module switch_channel_control (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic spi_clk_i,
    input wire logic cs_n_i,
    input wire logic mosi_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire switch_channel_control_pkg::chan_t direct_input_pin_i,
    input wire switch_channel_control_pkg::chan_t over_temp_i,
    input wire logic [`DYN_N-1:0] dyn_trip_i,
    input wire logic gnd_lost_i,
    output switch_channel_control_pkg::chan_t channel_gate_o,
    output logic [`LAMP_N-1:0] lamp_mode_bit_o,
    output switch_channel_control_pkg::chan_t error_flag_o,
    output switch_channel_control_pkg::chan_t thermal_latch_o
);
    import switch_channel_control_pkg::*;

    // ---------------- link domain ----------------
    logic link_rst;
    logic [2:0] fall_cnt_q;
    logic [2:0] rise_cnt_q;
    frame_t shift_q;
    frame_t rx_word_q;
    logic frame_tgl_q;
    logic clr_tgl_q;
    logic miso_q;
    frame_t tx_q;
    logic extra_q;

    assign link_rst = rst_i | cs_n_i;

    function automatic logic [2:0] next_cnt(input logic [2:0] c);
        next_cnt = 3'(c + 3'h1);
    endfunction : next_cnt

    // mosi sampled on falling edges
    always_ff @(negedge spi_clk_i or posedge link_rst) begin
        if (link_rst) begin
            fall_cnt_q <= 3'h0;
        end else begin
            fall_cnt_q <= next_cnt(fall_cnt_q);
        end
    end

    always_ff @(negedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= 8'h00;
        end else begin
            shift_q <= {shift_q[`FRAME_BITS-2:0], mosi_i};
        end
    end

    // a frame commits once, later edges in the same select are ignored
    always_ff @(negedge spi_clk_i or posedge link_rst) begin
        if (link_rst) begin
            extra_q <= 1'b0;
        end else if (fall_cnt_q == `FRAME_LAST) begin
            extra_q <= 1'b1;
        end
    end

    // whole frame held for the system side
    always_ff @(negedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_word_q <= 8'h00;
        end else if (!cs_n_i && !extra_q && fall_cnt_q == `FRAME_LAST) begin
            rx_word_q <= {shift_q[`FRAME_BITS-2:0], mosi_i};
        end
    end

    always_ff @(negedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_tgl_q <= 1'b0;
        end else if (!cs_n_i && !extra_q && fall_cnt_q == `FRAME_LAST) begin
            frame_tgl_q <= ~frame_tgl_q;
        end
    end

    // response bits launched on rising edges
    always_ff @(posedge spi_clk_i or posedge link_rst) begin
        if (link_rst) begin
            rise_cnt_q <= 3'h0;
        end else begin
            rise_cnt_q <= next_cnt(rise_cnt_q);
        end
    end

    always_ff @(posedge spi_clk_i or posedge link_rst) begin
        if (link_rst) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_q[3'(`FRAME_LAST - rise_cnt_q)];
        end
    end

    // second rising edge marks the flag clear point
    always_ff @(posedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clr_tgl_q <= 1'b0;
        end else if (!cs_n_i && rise_cnt_q == `CLR_EDGE) begin
            clr_tgl_q <= ~clr_tgl_q;
        end
    end

    assign miso_o = miso_q;
    assign miso_oe_o = ~cs_n_i;

    // ---------------- system domain ----------------
    logic frame_done;
    logic diag_sent;
    logic [`SYNC_W-1:0] pins_s;
    chan_t in_s;
    chan_t hot_s;
    logic [`DYN_N-1:0] dyn_s;
    logic gnd_lost_s;
    frame_t cmd;
    logic [2:0] hdr;
    logic is_write;
    chan_t on_q;
    logic [3:0] mode_q;
    chan_t latch_q;
    chan_t err_q;
    chan_t dyn_off;
    chan_t drive;
    chan_t gate_d;
    chan_t gate_q;
    logic ctl_cmd;
    resp_e resp_q;
    resp_e resp_d;
    logic wr_out;
    logic wr_mode;
    chan_t err_set;
    logic err_clr;
    logic cs_idle_s;
    logic [`LAMP_N-1:0] lamp_q;
    logic diag_hold_q;

    toggle_pulse u_frame_pulse (
        .clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tgl_i(frame_tgl_q),
        .pulse_o(frame_done)
    );

    toggle_pulse u_clr_pulse (
        .clk_i(sys_clk_i),
        .rst_i(rst_i),
        .tgl_i(clr_tgl_q),
        .pulse_o(diag_sent)
    );

    bit_sync #(
        .W(`SYNC_W)
    ) u_pin_sync (
        .clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i({gnd_lost_i, dyn_trip_i, over_temp_i, direct_input_pin_i}),
        .q_o(pins_s)
    );

    // select level seen on the system side, register words freeze while low
    bit_sync #(
        .W(1)
    ) u_cs_sync (
        .clk_i(sys_clk_i),
        .rst_i(rst_i),
        .d_i(cs_n_i),
        .q_o(cs_idle_s)
    );

    assign in_s = pins_s[`CH_N-1:0];
    assign hot_s = pins_s[2*`CH_N-1:`CH_N];
    assign dyn_s = pins_s[2*`CH_N+`DYN_N-1:2*`CH_N];
    assign gnd_lost_s = pins_s[`SYNC_W-1];

    // frame word is stable for a whole frame after the pulse
    assign cmd = rx_word_q;
    assign hdr = {cmd[`RB_BIT], cmd[`AD_BIT], cmd[`DR_BIT]};
    assign is_write = cmd[`WR_BIT];

    function automatic logic hdr_is(input logic [2:0] h, input logic [2:0] ref_h);
        hdr_is = (h == ref_h);
    endfunction : hdr_is

    assign ctl_cmd = frame_done && is_write && cmd[`RB_BIT]
        && hdr_is(hdr, `HDR_HW) && cmd[`CTL_BIT];
    assign wr_out = frame_done && is_write && !cmd[`RB_BIT];
    assign wr_mode = frame_done && is_write && hdr_is(hdr, `HDR_MODE);

    // on bits
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            on_q <= `OUT_RST;
        end else if (wr_out) begin
            on_q <= cmd[`CH_N-1:0];
        end
    end

    // combine select and lamp modes
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= `MODE_RST;
        end else if (wr_mode) begin
            mode_q <= cmd[`PWM_BIT:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lamp_q <= '0;
        end else begin
            lamp_q <= mode_q[`LED_MSB:0];
        end
    end

    assign lamp_mode_bit_o = lamp_q;

    // thermal latches: set wins over clear while still hot
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            latch_q <= '0;
        end else begin
            latch_q <= (ctl_cmd ? '0 : latch_q) | hot_s;
        end
    end

    assign thermal_latch_o = latch_q;

    // dynamic shutdown exists on channels 0..4 only
    assign dyn_off = {1'b0, dyn_s};

    assign err_set = dyn_off | latch_q;
    assign err_clr = diag_sent && resp_q == RESP_DIAG;

    // error flags: thermal or dynamic, cleared when diagnosis goes out
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            err_q <= '0;
        end else begin
            err_q <= (err_clr ? '0 : err_q) | err_set;
        end
    end

    assign error_flag_o = err_q;

    // combine of direct pin and on bit
    always_comb begin
        if (mode_q[`PWM_BIT]) begin
            drive = in_s & on_q;
        end else begin
            drive = in_s | on_q;
        end
    end

    always_comb begin
        gate_d = drive & ~latch_q & ~dyn_off & ~hot_s;
        if (gnd_lost_s) begin
            gate_d = '0;
            gate_d[`CH5] = gate_q[`CH5];
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gate_q <= '0;
        end else begin
            gate_q <= gate_d;
        end
    end

    assign channel_gate_o = gate_q;

    // next response: read frames of the on, mode or config register pick it, all else diagnosis
    always_comb begin
        resp_d = RESP_DIAG;
        if (!is_write) begin
            if (!cmd[`RB_BIT]) begin
                resp_d = RESP_OUT;
            end else if (hdr_is(hdr, `HDR_MODE)) begin
                resp_d = RESP_MODE;
            end else if (hdr_is(hdr, `HDR_HW)) begin
                resp_d = RESP_HW;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            resp_q <= RESP_DIAG;
        end else if (frame_done) begin
            resp_q <= resp_d;
        end
    end

    // diagnosis word is frozen from its second edge on
    function automatic logic cs_n_i_s_idle(input logic pulse);
        cs_n_i_s_idle = !pulse && !diag_hold_q;
    endfunction : cs_n_i_s_idle

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            diag_hold_q <= 1'b0;
        end else if (frame_done) begin
            diag_hold_q <= 1'b0;
        end else if (diag_sent) begin
            diag_hold_q <= 1'b1;
        end
    end

    // response word: register reads stable while a frame runs, diagnosis only from its second edge on
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_q <= 8'h00;
        end else if (cs_idle_s || resp_q == RESP_DIAG) begin
            unique case (resp_q)
                RESP_OUT: begin
                    tx_q <= {2'b00, on_q};
                end
                RESP_MODE: begin
                    tx_q <= {4'h0, mode_q};
                end
                RESP_HW: begin
                    tx_q <= 8'h00;
                end
                RESP_DIAG: begin
                    if (cs_n_i_s_idle(diag_sent)) begin
                        tx_q <= {2'b00, err_q};
                    end
                end
                default: begin
                    tx_q <= 8'h00;
                end
            endcase
        end
    end

endmodule : switch_channel_control

//--- core/switch_channel_control_consts.svh
/*
 Named constants for the six-channel switch control block: frame layout,
 register fields, reset values and channel counts.
 Assumes 8-bit frames, MSB first, and a host that keeps chip select high
 for at least four system clocks between frames.
*/
// Overview of operation
// - six on bits, one per channel, selected by bank bit 0, read and write
// - mode register at header 1,0,1: bit 3 combine select, bits 2..0 lamp mode
// - each channel drive is input pin OR or AND on bit, per selector
// - channels 0..2: lamp mode bit 0 is bulb, 1 is LED
// - over temperature switches channel off and sets a holding latch; under ground loss channel 5 holds its state even when hot
// - latched channel returns only after cooling and a clear command
// - clear command with bit 0 clears every thermal latch at once
// - channels 0..4 switch off on dynamic temperature trip
// - error flag set while channel is in dynamic shutdown
// - reading error flag clears it; set again if still in shutdown
// - ground loss forces channels 0..4 off; channel 5 holds its state
// - clear command is bit 0 of config register, header 1,1,0
// - error flags clear between second and third clock edge of diagnosis
`ifndef SWITCH_CHANNEL_CONTROL_CONSTS_SVH
`define SWITCH_CHANNEL_CONTROL_CONSTS_SVH
`define CH_N 6
`define DYN_N 5
`define LAMP_N 3
`define FRAME_BITS 8
`define FRAME_LAST 3'h7
`define WR_BIT 7
`define RB_BIT 6
`define AD_BIT 5
`define DR_BIT 4
`define HDR_MODE 3'h5
`define HDR_HW 3'h6
`define CTL_BIT 0
`define PWM_BIT 3
`define CLR_EDGE 3'h1
`define OUT_RST 6'h00
`define MODE_RST 4'h0
`define LED_MSB 2
`define CH5 5
`define SYNC_W 18
`endif

//--- core/switch_channel_control_pkg.sv
/*
 Types shared by the switch control block.
 Assumes the constants header is included by each user.
*/
package switch_channel_control_pkg;
    typedef enum logic [3:0] {
        RESP_DIAG = 4'h1,
        RESP_OUT = 4'h2,
        RESP_MODE = 4'h4,
        RESP_HW = 4'h8
    } resp_e;
    typedef logic [7:0] frame_t;
    typedef logic [5:0] chan_t;
endpackage : switch_channel_control_pkg

//--- core/toggle_pulse.sv
/*
 Turns a toggle from another clock domain into a one-cycle pulse.
 Assumes toggles are spaced by more than three destination clocks.
*/
`timescale 1ns/1ps
module toggle_pulse (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tgl_i,
    output logic pulse_o
);
    logic meta_q;
    logic sync_q;
    logic last_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= tgl_i;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign pulse_o = sync_q ^ last_q;
endmodule : toggle_pulse

//--- test/spi_host_model.sv
/* host serial master, mode 1, eight bit frames, 80 ns clock
   assumes the bench calls xfer one at a time */
`timescale 1ns/1ps
module spi_host_model (
    output logic spi_clk_o,
    output logic cs_n_o,
    output logic mosi_o,
    input wire logic miso_i
);
    event done_e;
    logic [7:0] rx_q;
    initial begin
        spi_clk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx);
        #13 cs_n_o = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #40 spi_clk_o = 1'b1;
            mosi_o = tx[i];
            #40 spi_clk_o = 1'b0;
            rx_q[i] = miso_i;
        end
        #20 cs_n_o = 1'b1;
        mosi_o = ~mosi_o;
        ->done_e;
        #200;
    endtask : xfer
endmodule : spi_host_model

//--- test/switch_channel_control_chk.sv
/* assertions on the switch control top ports
   assumes binding to the top module below */
`timescale 1ns/1ps
module switch_channel_control_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic cs_n_i,
    input wire logic miso_oe_o,
    input wire switch_channel_control_pkg::chan_t over_temp_i,
    input wire logic [4:0] dyn_trip_i,
    input wire logic gnd_lost_i,
    input wire switch_channel_control_pkg::chan_t channel_gate_o,
    input wire logic [2:0] lamp_mode_bit_o,
    input wire switch_channel_control_pkg::chan_t error_flag_o,
    input wire switch_channel_control_pkg::chan_t thermal_latch_o
);
    import switch_channel_control_pkg::*;
    logic [2:0] up_q;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_q <= 3'h0;
        end else if (up_q != 3'h7) begin
            up_q <= up_q + 3'h1;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    oe_follow_a: assert property (miso_oe_o == !cs_n_i) else $error("oe not tracking select");
    hot_off_a: assert property (up_q == 3'h7 |->
        (over_temp_i & $past(over_temp_i, 4) & channel_gate_o) == 6'h00) else $error("hot on");
    latch_set_a: assert property (up_q == 3'h7 |->
        (over_temp_i & $past(over_temp_i, 4) & ~thermal_latch_o) == 6'h00) else $error("no latch");
    dyn_off_a: assert property (up_q == 3'h7 |->
        (dyn_trip_i & $past(dyn_trip_i, 4) & channel_gate_o[4:0]) == 5'h00) else $error("dyn on");
    err_set_a: assert property (up_q == 3'h7 |->
        (dyn_trip_i & $past(dyn_trip_i, 4) & ~error_flag_o[4:0]) == 5'h00) else $error("no err");
    gnd_off_a: assert property (gnd_lost_i && $past(gnd_lost_i, 4) |->
        channel_gate_o[4:0] == 5'h00) else $error("gnd lost yet on");
    ch5_hold_a: assert property (gnd_lost_i && $past(gnd_lost_i, 4) |=>
        $stable(channel_gate_o[5])) else $error("ch5 moved");
    latch_clear_a: assert property (($past(thermal_latch_o) & ~thermal_latch_o) != 6'h00
        |-> cs_n_i) else $error("latch cleared in frame");
    lamp_hold_a: assert property ($changed(lamp_mode_bit_o) |-> cs_n_i) else $error("lamp");
endmodule : switch_channel_control_chk
bind switch_channel_control switch_channel_control_chk i_chk (.sys_clk_i, .rst_i, .cs_n_i,
    .miso_oe_o, .over_temp_i, .dyn_trip_i, .gnd_lost_i, .channel_gate_o, .lamp_mode_bit_o,
    .error_flag_o, .thermal_latch_o);

//--- test/switch_channel_control_tb_top.sv
/* self-checking bench for the switch control block
   assumes outputs settle within six system clocks */
`timescale 1ns/1ps
module switch_channel_control_tb_top;
    import switch_channel_control_pkg::*;
    logic sys_clk_i, rst_i, spi_clk, cs_n, mosi, miso, miso_oe, gnd_lost;
    chan_t pins, hot, gate, err, latch;
    logic [4:0] dyn;
    logic [2:0] lamp;
    logic [7:0] q[$];
    logic [7:0] pend;
    logic [15:0] rs;
    int n_fail, n_checks, cyc;
    switch_channel_control i_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .spi_clk_i(spi_clk),
        .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
        .direct_input_pin_i(pins), .over_temp_i(hot), .dyn_trip_i(dyn),
        .gnd_lost_i(gnd_lost), .channel_gate_o(gate), .lamp_mode_bit_o(lamp),
        .error_flag_o(err), .thermal_latch_o(latch));
    spi_host_model i_host (.spi_clk_o(spi_clk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask : wt
    task automatic frame(input logic [7:0] tx, input logic [7:0] nxt);
        q.push_back(pend);
        pend = nxt;
        i_host.xfer(tx);
        wt(10);
    endtask : frame
    always @(i_host.done_e) begin
        if (q[0] != 8'hFF) begin
            chk(i_host.rx_q, q[0]);
        end
        void'(q.pop_front());
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        rst_i = 1'b1;
        pins = 6'h00;
        hot = 6'h00;
        dyn = 5'h00;
        gnd_lost = 1'b0;
        pend = 8'hFF;
        rs = 16'h4F9C;
        repeat (4) @(posedge sys_clk_i);
        #2 rst_i = 1'b0;
        wt(6);
        chk({2'h0, gate}, 8'h00);
        chk({2'h0, latch}, 8'h00);
        for (int c = 0; c < 2; c++) begin
            rs = lfsr(rs);
            frame({2'h2, rs[5:0]}, 8'h00);
            frame({4'hD, c[0], rs[14:12]}, 8'h00);
            pins = rs[11:6];
            wt(6);
            chk({2'h0, gate}, {2'h0, c ? (rs[11:6] & rs[5:0]) : (rs[11:6] | rs[5:0])});
            chk({5'h00, lamp}, {5'h00, rs[14:12]});
            frame(8'h00, {2'h0, rs[5:0]});
            frame(8'h50, {4'h0, c[0], rs[14:12]});
        end
        frame(8'hBF, 8'h00);
        frame(8'hD0, 8'hFF);
        pins = 6'h00;
        hot = 6'h05;
        wt(6);
        chk({2'h0, gate}, 8'h3A);
        frame(8'hE1, 8'hFF);
        chk({2'h0, latch}, 8'h05);
        hot = 6'h00;
        wt(6);
        chk({2'h0, gate}, 8'h3A);
        frame(8'hE0, 8'hFF);
        chk({2'h0, latch}, 8'h05);
        frame(8'hE1, 8'hFF);
        chk({2'h0, latch}, 8'h00);
        chk({2'h0, gate}, 8'h3F);
        frame(8'hBF, 8'h00);
        frame(8'hBF, 8'hFF);
        dyn = 5'h12;
        wt(6);
        chk({2'h0, gate}, 8'h2D);
        chk({2'h0, err}, 8'h12);
        frame(8'hBF, 8'h12);
        chk({2'h0, err}, 8'h12);
        dyn = 5'h00;
        wt(6);
        chk({2'h0, err}, 8'h12);
        frame(8'hBF, 8'h00);
        chk({2'h0, err}, 8'h00);
        frame(8'hBF, 8'hFF);
        gnd_lost = 1'b1;
        wt(6);
        chk({2'h0, gate}, 8'h20);
        end_of_test();
    end
endmodule : switch_channel_control_tb_top
